// ### rtl/spsd_top.sv
// Delay-locked loop controller: turns the phase comparator direction into a delay
// setting, adds the phase offset and drives the per-pin strobe logic and the array.
// Assumes the comparator level and the pin reset are asynchronous to i_clk.
// How it works
// - Loop locks and gives settings for references from 100 to 400 MHz.
// - Up to 256 cycles to find the period; data meanwhile is unreliable.
// - Below 100 MHz a fixed 2.5 ns shift; more only via offset.
// - Four frequency modes 0 to 3, each with range, shifts and chain length.
// - Modes 0-2 ranges; modes 0 and 2 use 12 elements, mode 1 uses 16.
// - Mode 3 spans 240-400 or 240-350 MHz with 10 elements.
// - Delay setting is 6 bits in mode 0, 5 bits in modes 1-3.
// - Reset from array or pin; each reset restarts the 256-cycle wait.
// - Reference passes up to 16 delay elements; comparator checks chain output.
// - Comparator direction steps a six-bit up/down delay counter.
// - Zero-degree shift bypasses the strobe logic block; the loop still drives the array.
// - Delay setting goes to strobe blocks and array; offset only to strobe.
// - Offset is two's complement: -64..63 in mode 0, -32..31 otherwise.
// - Offset sum saturates at 0 and at 64 or 32.
// - Static offset: positive adds, negative subtracts.
// - Each strobe pin and its complement has its own logic block.
`timescale 1ns/1ps
module spsd_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin_reset_n,
  input wire logic i_array_reset,
  input wire logic [1:0] i_freq_mode,
  input wire logic i_fast_grade,
  input wire logic i_low_freq,
  input wire logic i_chain_early,
  input wire logic [2:0] i_shift_sel,
  input wire logic [1:0] i_offset_mode,
  input wire logic signed [6:0] i_static_offset,
  input wire logic [5:0] i_dyn_offset,
  input wire logic i_add_not_sub,
  output logic o_locked,
  output logic o_bypass,
  output logic o_upndn,
  output logic [5:0] o_delay_to_array,
  output logic [5:0] o_delay_to_strobe,
  output logic signed [6:0] o_offset_to_strobe,
  output logic [6:0] o_strobe_setting,
  output logic [4:0] o_chain_elems,
  output logic [2:0] o_strobe_taps,
  output logic [9:0] o_step_tenth_deg,
  output logic [8:0] o_range_max_mhz
);

  function automatic logic [5:0] cnt_max(input logic [1:0] mode);
    cnt_max = (mode == 2'h0) ? spsd_pkg::CNT_MAX_WIDE : spsd_pkg::CNT_MAX_NARROW;
  endfunction : cnt_max

  function automatic logic [4:0] chain_elems(input logic [1:0] mode);
    unique case (mode)
      2'h0: chain_elems = spsd_pkg::ELEMS_M0;
      2'h1: chain_elems = spsd_pkg::ELEMS_M1;
      2'h2: chain_elems = spsd_pkg::ELEMS_M2;
      2'h3: chain_elems = spsd_pkg::ELEMS_M3;
    endcase
  endfunction : chain_elems

  // Two-stage synchronisers for the pin reset and comparator level
  logic pin_rst_s1;
  logic pin_rst_s2;
  logic cmp_s1;
  logic cmp_s2;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_rst_s1 <= 1'b1;
      pin_rst_s2 <= 1'b1;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      pin_rst_s1 <= i_pin_reset_n;
      pin_rst_s2 <= pin_rst_s1;
      cmp_s1 <= i_chain_early;
      cmp_s2 <= cmp_s1;
    end
  end

  logic [1:0] mode_q;
  logic low_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_q <= 2'h0;
      low_q <= 1'b0;
    end else begin
      mode_q <= i_freq_mode;
      low_q <= i_low_freq;
    end
  end

  // A loop reset from pin or array, or a mode change, restarts the settle wait
  logic restart;
  assign restart = !pin_rst_s2 || i_array_reset || (mode_q != i_freq_mode)
    || (low_q != i_low_freq);

  spsd_pkg::spsd_state_t st;
  spsd_pkg::spsd_state_t next_st;
  logic [7:0] settle_cnt;
  always_comb begin
    next_st = st;
    unique case (st)
      spsd_pkg::SPSD_SETTLE: begin
        if (settle_cnt == spsd_pkg::SETTLE_LAST) begin
          next_st = low_q ? spsd_pkg::SPSD_FIXED : spsd_pkg::SPSD_LOCKED;
        end
      end
      spsd_pkg::SPSD_LOCKED: next_st = spsd_pkg::SPSD_LOCKED;
      spsd_pkg::SPSD_FIXED: next_st = spsd_pkg::SPSD_FIXED;
      default: next_st = spsd_pkg::SPSD_SETTLE;
    endcase
    if (restart) begin
      next_st = spsd_pkg::SPSD_SETTLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= spsd_pkg::SPSD_SETTLE;
      o_locked <= 1'b0;
    end else begin
      st <= next_st;
      o_locked <= (next_st != spsd_pkg::SPSD_SETTLE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || restart) begin
      settle_cnt <= 8'h00;
    end else if (st == spsd_pkg::SPSD_SETTLE && settle_cnt != spsd_pkg::SETTLE_LAST) begin
      settle_cnt <= settle_cnt + 8'h01;
    end
  end

  // Up/down delay counter driven by comparator direction
  logic [5:0] dly;
  logic [5:0] next_dly;
  always_comb begin
    next_dly = dly;
    if (restart) begin
      next_dly = spsd_pkg::DLY_RESET;
    end else if (st == spsd_pkg::SPSD_FIXED) begin
      next_dly = spsd_pkg::LOW_SHIFT_SET;
    end else if (cmp_s2) begin
      if (dly < cnt_max(mode_q)) begin
        next_dly = dly + 6'h01;
      end
    end else if (dly != 6'h00) begin
      next_dly = dly - 6'h01;
    end
    if (next_dly > cnt_max(mode_q)) begin
      next_dly = cnt_max(mode_q);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dly <= spsd_pkg::DLY_RESET;
      o_upndn <= 1'b0;
    end else begin
      dly <= next_dly;
      o_upndn <= cmp_s2;
    end
  end

  // Offset selection, clamp to the mode's two's complement range
  logic signed [7:0] ofs_raw;
  logic signed [7:0] ofs;
  logic signed [8:0] sum;
  logic [6:0] next_set;
  logic [6:0] ceil_set;
  always_comb begin
    unique case (spsd_pkg::spsd_ofs_mode_t'(i_offset_mode))
      spsd_pkg::SPSD_OFS_STATIC: ofs_raw = 8'(i_static_offset);
      spsd_pkg::SPSD_OFS_ADD: ofs_raw = $signed({2'b00, i_dyn_offset});
      spsd_pkg::SPSD_OFS_SUB: ofs_raw = -$signed({2'b00, i_dyn_offset});
      spsd_pkg::SPSD_OFS_BOTH: begin
        ofs_raw = i_add_not_sub ? $signed({2'b00, i_dyn_offset})
          : -$signed({2'b00, i_dyn_offset});
      end
    endcase
    if (mode_q == 2'h0) begin
      ofs = (ofs_raw < spsd_pkg::OFS_MIN_WIDE) ? spsd_pkg::OFS_MIN_WIDE
        : (ofs_raw > spsd_pkg::OFS_MAX_WIDE) ? spsd_pkg::OFS_MAX_WIDE : ofs_raw;
      ceil_set = spsd_pkg::SET_CEIL_WIDE;
    end else begin
      ofs = (ofs_raw < spsd_pkg::OFS_MIN_NARROW) ? spsd_pkg::OFS_MIN_NARROW
        : (ofs_raw > spsd_pkg::OFS_MAX_NARROW) ? spsd_pkg::OFS_MAX_NARROW : ofs_raw;
      ceil_set = spsd_pkg::SET_CEIL_NARROW;
    end
    sum = $signed({3'b000, dly}) + 9'(ofs);
    if (sum < 9'sd0) begin
      next_set = 7'h00;
    end else if (sum > $signed({2'b00, ceil_set})) begin
      next_set = ceil_set;
    end else begin
      next_set = sum[6:0];
    end
    if (i_shift_sel == 3'h0) begin
      next_set = 7'h00;
    end
  end

  // Settings to the per-pin strobe blocks and the logic array
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_delay_to_array <= spsd_pkg::DLY_RESET;
      o_delay_to_strobe <= spsd_pkg::DLY_RESET;
      o_offset_to_strobe <= 7'sd0;
      o_strobe_setting <= 7'h00;
      o_bypass <= 1'b1;
      o_strobe_taps <= 3'h0;
    end else begin
      o_delay_to_array <= next_dly;
      o_delay_to_strobe <= (i_shift_sel == 3'h0) ? 6'h00 : next_dly;
      o_offset_to_strobe <= (i_shift_sel == 3'h0) ? 7'sd0 : ofs[6:0];
      o_strobe_setting <= next_set;
      o_bypass <= (i_shift_sel == 3'h0);
      o_strobe_taps <= (i_shift_sel > spsd_pkg::SHIFT_STEPS) ? spsd_pkg::SHIFT_STEPS
        : i_shift_sel;
    end
  end

  // Chain length, phase step and frequency ceiling of the selected mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_chain_elems <= spsd_pkg::ELEMS_M0;
      o_step_tenth_deg <= spsd_pkg::STEP_M0;
      o_range_max_mhz <= 9'(spsd_pkg::M0_MAX_MHZ);
    end else begin
      o_chain_elems <= chain_elems(i_freq_mode);
      unique case (i_freq_mode)
        2'h0: begin
          o_step_tenth_deg <= spsd_pkg::STEP_M0;
          o_range_max_mhz <= 9'(spsd_pkg::M0_MAX_MHZ);
        end
        2'h1: begin
          o_step_tenth_deg <= spsd_pkg::STEP_M1;
          o_range_max_mhz <= 9'(spsd_pkg::M1_MAX_MHZ);
        end
        2'h2: begin
          o_step_tenth_deg <= spsd_pkg::STEP_M0;
          o_range_max_mhz <= 9'(spsd_pkg::M2_MAX_MHZ);
        end
        2'h3: begin
          o_step_tenth_deg <= spsd_pkg::STEP_M3;
          o_range_max_mhz <= i_fast_grade ? 9'(spsd_pkg::M3_MAX_FAST_MHZ)
            : 9'(spsd_pkg::M3_MAX_SLOW_MHZ);
        end
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_no_lock_in_settle;
    (st == spsd_pkg::SPSD_SETTLE) |-> !o_locked;
  endproperty
  a_no_lock_in_settle: assert property (p_no_lock_in_settle)
    else $error("locked during settle");

  property p_lock_after_full_count;
    $rose(o_locked) |-> $past(settle_cnt) == spsd_pkg::SETTLE_LAST;
  endproperty
  a_lock_after_full_count: assert property (p_lock_after_full_count)
    else $error("lock before 256 cycles");

  property p_restart_drops_lock;
    restart |=> !o_locked && settle_cnt == 8'h00;
  endproperty
  a_restart_drops_lock: assert property (p_restart_drops_lock)
    else $error("reset did not restart settle");

  property p_narrow_width;
    (mode_q != 2'h0) |-> dly <= spsd_pkg::CNT_MAX_NARROW;
  endproperty
  a_narrow_width: assert property (p_narrow_width)
    else $error("delay exceeds 5 bits");

  property p_count_up;
    (st == spsd_pkg::SPSD_LOCKED && cmp_s2 && !restart && dly < cnt_max(mode_q))
      |=> dly == $past(dly) + 6'h01;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not step up");

  property p_sat_zero;
    (st == spsd_pkg::SPSD_LOCKED && !cmp_s2 && dly == 6'h00 && !restart) |=> dly == 6'h00;
  endproperty
  a_sat_zero: assert property (p_sat_zero)
    else $error("counter wrapped below zero");

  property p_fixed_shift;
    (st == spsd_pkg::SPSD_FIXED) |=> (dly == spsd_pkg::LOW_SHIFT_SET) || $past(restart);
  endproperty
  a_fixed_shift: assert property (p_fixed_shift)
    else $error("fixed shift not applied");

  property p_bypass;
    (i_shift_sel == 3'h0) |=> o_bypass && o_strobe_setting == 7'h00 && o_delay_to_strobe == 6'h00;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("zero shift not bypassed");

  property p_set_ceiling;
    o_strobe_setting <= spsd_pkg::SET_CEIL_WIDE;
  endproperty
  a_set_ceiling: assert property (p_set_ceiling)
    else $error("strobe setting above ceiling");

  property p_count_down;
    (st == spsd_pkg::SPSD_LOCKED && !cmp_s2 && !restart && dly != 6'h00)
      |=> dly == $past(dly) - 6'h01;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("counter did not step down");

  property p_sat_top;
    (st == spsd_pkg::SPSD_LOCKED && cmp_s2 && !restart && dly == cnt_max(mode_q))
      |=> dly == $past(dly);
  endproperty
  a_sat_top: assert property (p_sat_top)
    else $error("counter wrapped above mode maximum");

  property p_upndn_follows;
    1'b1 |=> o_upndn == $past(cmp_s2);
  endproperty
  a_upndn_follows: assert property (p_upndn_follows)
    else $error("direction output lost the comparator");

  property p_narrow_offset;
    (mode_q != 2'h0) |=> o_offset_to_strobe >= -7'sd32 && o_offset_to_strobe <= 7'sd31;
  endproperty
  a_narrow_offset: assert property (p_narrow_offset)
    else $error("offset outside narrow range");

  property p_bypass_offset;
    (i_shift_sel == 3'h0) |=> o_offset_to_strobe == 7'sd0;
  endproperty
  a_bypass_offset: assert property (p_bypass_offset)
    else $error("offset reached strobe block in bypass");

  c_lock: cover property ($rose(o_locked));
  c_fixed: cover property (st == spsd_pkg::SPSD_FIXED);
  c_sat_top: cover property (o_strobe_setting == spsd_pkg::SET_CEIL_NARROW);
  c_restart_locked: cover property (o_locked ##1 restart);

endmodule : spsd_top

// ### rtl/spsd_pkg.sv
// Constants for the strobe phase-shift delay-locked loop controller.
// Assumes one 200 MHz reference clock that matches the read strobe rate.
package spsd_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // Reference range the loop supports, in MHz
  localparam int REF_MIN_MHZ = 100;
  localparam int REF_MAX_MHZ = 400;
  // Per-mode ranges in MHz; mode 3 top end depends on speed grade
  localparam int M0_MIN_MHZ = 100;
  localparam int M0_MAX_MHZ = 175;
  localparam int M1_MIN_MHZ = 150;
  localparam int M1_MAX_MHZ = 230;
  localparam int M2_MIN_MHZ = 200;
  localparam int M2_MAX_MHZ = 310;
  localparam int M3_MIN_MHZ = 240;
  localparam int M3_MAX_FAST_MHZ = 400;
  localparam int M3_MAX_SLOW_MHZ = 350;
  // Settle interval after every reset, in reference cycles
  localparam int SETTLE_CYCLES = 256;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
  // Fixed shift for interfaces below the lowest mode
  localparam int LOW_SHIFT_PS = 2500;
  localparam int ELEM_DELAY_PS = 416;
  localparam logic [5:0] LOW_SHIFT_SET = 6'((LOW_SHIFT_PS + ELEM_DELAY_PS - 1) / ELEM_DELAY_PS);
  // Delay elements in the chain per mode
  localparam logic [4:0] ELEMS_M0 = 5'h0c;
  localparam logic [4:0] ELEMS_M1 = 5'h10;
  localparam logic [4:0] ELEMS_M2 = 5'h0c;
  localparam logic [4:0] ELEMS_M3 = 5'h0a;
  // Phase step per element in tenths of a degree
  localparam logic [9:0] STEP_M0 = 10'h12c;
  localparam logic [9:0] STEP_M1 = 10'h0e1;
  localparam logic [9:0] STEP_M3 = 10'h168;
  localparam logic [2:0] SHIFT_STEPS = 3'h4;
  // Counter full scale (6 bits in mode 0, 5 bits otherwise)
  localparam logic [5:0] CNT_MAX_WIDE = 6'h3f;
  localparam logic [5:0] CNT_MAX_NARROW = 6'h1f;
  // Ceiling of the strobe setting after offset
  localparam logic [6:0] SET_CEIL_WIDE = 7'h40;
  localparam logic [6:0] SET_CEIL_NARROW = 7'h20;
  // Offset limits, two's complement
  localparam logic signed [7:0] OFS_MIN_WIDE = -8'sd64;
  localparam logic signed [7:0] OFS_MAX_WIDE = 8'sd63;
  localparam logic signed [7:0] OFS_MIN_NARROW = -8'sd32;
  localparam logic signed [7:0] OFS_MAX_NARROW = 8'sd31;
  localparam logic [5:0] DLY_RESET = 6'h00;
  typedef enum logic [1:0] {
    SPSD_OFS_STATIC = 2'h0,
    SPSD_OFS_ADD = 2'h1,
    SPSD_OFS_SUB = 2'h2,
    SPSD_OFS_BOTH = 2'h3
  } spsd_ofs_mode_t;
  typedef enum logic [2:0] {
    SPSD_SETTLE = 3'b001,
    SPSD_LOCKED = 3'b010,
    SPSD_FIXED = 3'b100
  } spsd_state_t;
endpackage : spsd_pkg

// ### sim/spsd_phase_det_model.sv
// Phase detector model: chain output compared against the ideal setting for the period.
// Assumes the bench picks the ideal setting that the reference period implies.
`timescale 1ns/1ps
module spsd_phase_det_model (
  input wire logic i_clk,
  input wire logic [5:0] i_delay,
  input wire logic [6:0] i_target,
  output logic o_chain_early
);
  // Chain output leads the reference while the setting is too short; a target beyond
  // the counter's reach keeps it leading, so the counter rests at its ceiling
  always_ff @(posedge i_clk) begin
    o_chain_early <= ({1'b0, i_delay} < i_target);
  end
endmodule : spsd_phase_det_model

// ### sim/spsd_top_tb_top.sv
// Self-checking bench for the strobe phase-shift loop controller.
// Assumes the phase detector model closes the loop around the design.
`timescale 1ns/1ps
module spsd_top_tb_top;
  logic i_clk, i_rst_n, i_pin_reset_n, i_array_reset, i_fast_grade, i_low_freq;
  logic i_chain_early, i_add_not_sub, o_locked, o_bypass, o_upndn;
  logic [1:0] i_freq_mode, i_offset_mode;
  logic [2:0] i_shift_sel, o_strobe_taps;
  logic signed [6:0] i_static_offset, o_offset_to_strobe;
  logic [5:0] i_dyn_offset, o_delay_to_array, o_delay_to_strobe;
  logic [6:0] o_strobe_setting, target;
  logic [4:0] o_chain_elems;
  logic [9:0] o_step_tenth_deg;
  logic [8:0] o_range_max_mhz;
  int bad_count, num_checks, n;
  logic [9:0] elems [4] = '{10'h00c, 10'h010, 10'h00c, 10'h00a};
  logic [9:0] steps [4] = '{10'h12c, 10'h0e1, 10'h12c, 10'h168};
  logic [9:0] tops [4] = '{10'h0af, 10'h0e6, 10'h136, 10'h190};

  spsd_top spsd_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin_reset_n(i_pin_reset_n),
    .i_array_reset(i_array_reset), .i_freq_mode(i_freq_mode), .i_fast_grade(i_fast_grade),
    .i_low_freq(i_low_freq), .i_chain_early(i_chain_early), .i_shift_sel(i_shift_sel),
    .i_offset_mode(i_offset_mode), .i_static_offset(i_static_offset),
    .i_dyn_offset(i_dyn_offset), .i_add_not_sub(i_add_not_sub), .o_locked(o_locked),
    .o_bypass(o_bypass), .o_upndn(o_upndn), .o_delay_to_array(o_delay_to_array),
    .o_delay_to_strobe(o_delay_to_strobe), .o_offset_to_strobe(o_offset_to_strobe),
    .o_strobe_setting(o_strobe_setting), .o_chain_elems(o_chain_elems),
    .o_strobe_taps(o_strobe_taps), .o_step_tenth_deg(o_step_tenth_deg),
    .o_range_max_mhz(o_range_max_mhz));
  spsd_phase_det_model spsd_phase_det_model_inst (.i_clk(i_clk), .i_delay(o_delay_to_array),
    .i_target(target), .o_chain_early(i_chain_early));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
  endtask : tick

  // Settled sampling point between drive edges
  task automatic look;
    @(negedge i_clk);
  endtask : look

  task automatic wait_lock;
    n = 0;
    while (o_locked !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("CHECK FAILED lock wait expected below 400 seen %0d", n);
      close_out();
    end else begin
      chk("settle length", 10'h001, {9'h000, n >= 245 && n <= 260});
      @(posedge i_clk);
    end
  endtask : wait_lock

  task automatic ofs(input logic [1:0] md, input logic [6:0] st, input logic [5:0] dy,
      input logic ad, input logic [6:0] e_ofs, input logic [6:0] e_set);
    i_offset_mode <= md;
    i_static_offset <= st;
    i_dyn_offset <= dy;
    i_add_not_sub <= ad;
    tick(3);
    look();
    chk("offset", {3'h0, e_ofs}, {3'h0, o_offset_to_strobe});
    chk("strobe setting", {3'h0, e_set}, {3'h0, o_strobe_setting});
    @(posedge i_clk);
  endtask : ofs

  initial begin
    bad_count = 0;
    num_checks = 0;
    {i_rst_n, i_array_reset, i_low_freq, i_freq_mode, i_offset_mode} = '0;
    {i_pin_reset_n, i_fast_grade, i_add_not_sub} = '1;
    i_shift_sel = 3'h4;
    i_static_offset = '0;
    i_dyn_offset = '0;
    target = 7'h14;
    tick(8);
    look();
    chk("reset lock", 10'h000, {9'h000, o_locked});
    chk("reset chain", elems[0], {5'h00, o_chain_elems});
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    wait_lock();
    tick(40);
    look();
    // Four cycles of loop lag dither the setting from target - 4 to target + 3
    chk("lock window", 10'h001, {9'h000, o_delay_to_array inside {[6'h10:6'h17]}});
    for (int m = 0; m < 4; m++) begin
      @(posedge i_clk);
      i_freq_mode <= 2'(m);
      tick(3);
      look();
      chk("chain", elems[m], {5'h00, o_chain_elems});
      chk("step", steps[m], o_step_tenth_deg);
      chk("range", tops[m], {1'b0, o_range_max_mhz});
    end
    @(posedge i_clk);
    i_fast_grade <= 1'b0;
    tick(3);
    look();
    chk("range slow", 10'h15e, {1'b0, o_range_max_mhz});
    @(posedge i_clk);
    i_freq_mode <= 2'h1;
    target <= 7'h7f;
    tick(300);
    look();
    chk("narrow top", 10'h01f, {4'h0, o_delay_to_array});
    chk("upndn up", 10'h001, {9'h000, o_upndn});
    target <= 7'h00;
    tick(80);
    look();
    chk("floor", 10'h000, {4'h0, o_delay_to_array});
    chk("upndn down", 10'h000, {9'h000, o_upndn});
    target <= 7'h7f;
    tick(80);
    ofs(2'h0, 7'h05, 6'h00, 1'b1, 7'h05, 7'h20);
    ofs(2'h0, 7'h76, 6'h00, 1'b1, 7'h76, 7'h15);
    ofs(2'h0, 7'h58, 6'h00, 1'b1, 7'h60, 7'h00);
    ofs(2'h1, 7'h00, 6'h01, 1'b0, 7'h01, 7'h20);
    ofs(2'h2, 7'h00, 6'h0a, 1'b1, 7'h76, 7'h15);
    ofs(2'h3, 7'h00, 6'h03, 1'b0, 7'h7d, 7'h1c);
    ofs(2'h3, 7'h00, 6'h03, 1'b1, 7'h03, 7'h20);
    i_shift_sel <= 3'h0;
    tick(3);
    look();
    chk("bypass", 10'h001, {9'h000, o_bypass});
    chk("bypass setting", 10'h000, {3'h0, o_strobe_setting});
    chk("bypass strobe", 10'h000, {4'h0, o_delay_to_strobe});
    chk("array keeps", 10'h01f, {4'h0, o_delay_to_array});
    @(posedge i_clk);
    i_shift_sel <= 3'h7;
    tick(3);
    look();
    chk("taps clamp", 10'h004, {7'h00, o_strobe_taps});
    chk("no bypass", 10'h000, {9'h000, o_bypass});
    chk("strobe delay", 10'h01f, {4'h0, o_delay_to_strobe});
    @(posedge i_clk);
    i_freq_mode <= 2'h0;
    tick(300);
    look();
    chk("wide top", 10'h03f, {4'h0, o_delay_to_array});
    @(posedge i_clk);
    ofs(2'h0, 7'h01, 6'h00, 1'b1, 7'h01, 7'h40);
    ofs(2'h0, 7'h40, 6'h00, 1'b1, 7'h40, 7'h00);
    i_array_reset <= 1'b1;
    tick(1);
    i_array_reset <= 1'b0;
    tick(2);
    look();
    chk("array restart", 10'h000, {9'h000, o_locked});
    wait_lock();
    i_pin_reset_n <= 1'b0;
    tick(1);
    i_pin_reset_n <= 1'b1;
    tick(4);
    look();
    chk("pin restart", 10'h000, {9'h000, o_locked});
    wait_lock();
    i_low_freq <= 1'b1;
    tick(3);
    wait_lock();
    tick(2);
    look();
    chk("low shift", {4'h0, spsd_pkg::LOW_SHIFT_SET}, {4'h0, o_delay_to_array});
    close_out();
  end
endmodule : spsd_top_tb_top
